// File: core/pwr_seq_pkg.sv
// constants and types shared by the power-mode sequencer
`default_nettype none
package pwr_seq_pkg;

    // ****************************************
    // register bus
    // ****************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFS_SLEEP_KEY = 8'h40;
    localparam logic [ADDR_W-1:0] OFS_SLEEP_CMD = 8'h44;
    localparam logic [ADDR_W-1:0] OFS_WAKE_CAUSE = 8'h48;
    localparam logic [ADDR_W-1:0] OFS_WAKE_ENABLE = 8'h4C;
    localparam logic [ADDR_W-1:0] OFS_SUPPLY_WAIT = 8'h50;
    localparam logic [ADDR_W-1:0] OFS_CLOCK_WAIT = 8'h54;
    localparam logic [ADDR_W-1:0] OFS_MODE_STATUS = 8'h58;
    localparam logic [ADDR_W-1:0] OFS_SLOW_CLOCK_MUX_CTRL = 8'h7C;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int MUX_SEL_BIT = 0;
    localparam int MUX_STATUS_BIT = 31;
    localparam logic MUX_SEL_RST = 1'h0;
    localparam int WAKE_SRC_W = 4;
    localparam logic [WAKE_SRC_W-1:0] WAKE_EN_RST = 4'hF;
    localparam int CAUSE_W = 8;
    localparam int CAUSE_EXT_BIT = 0;
    localparam int CAUSE_WAKE_BIT = 1;
    localparam int CAUSE_SRC_LSB = 4;
    localparam logic [CAUSE_W-1:0] CAUSE_RST = 8'h01;
    localparam int STATUS_GATED_BIT = 0;
    localparam int STATUS_UNLOCKED_BIT = 1;
    localparam int STATUS_ASLEEP_BIT = 2;

    // ****************************************
    // timing (in system-clock cycles)
    // ****************************************
    localparam int WAIT_W = 16;
    localparam logic [WAIT_W-1:0] SUPPLY_WAIT_RST = 16'h0010;
    localparam logic [WAIT_W-1:0] CLOCK_WAIT_RST = 16'h0008;
    localparam logic [WAIT_W-1:0] WAIT_STEP = 16'h0001;
    localparam int UNLOCK_W = 8;
    localparam logic [UNLOCK_W-1:0] UNLOCK_STEP = 8'h01;

    // ****************************************
    // sequencer states
    // ****************************************
    typedef enum logic [2:0] {
        ST_RUN,
        ST_WAIT,
        ST_PDOWN,
        ST_SLEEP,
        ST_PWRUP,
        ST_CLKUP
    } pm_state_t;

endpackage
`default_nettype wire

// File: core/power_mode_sequencer.sv
// always-on power-mode sequencer with slow-clock source selection
//
// How it works
// R1: select pad low picks external slow clock
// R2: software selector bit 0 resets to zero
// R3: bit 31 reads select pad level
// R4: after reset slow clock follows pad
// R5: wakeup forces fast clock to default
// R6: three modes: run, wait, sleep
// R7: wait instruction gates pipeline clock
// R8: local or controller interrupt ends wait
// R9: software checks status after leaving wait
// R10: sleep command needs prior key write
// R11: power-down drops supplies, floats pads
// R12: enabled wake event starts wakeup
// R13: supplies on first, all resets held
// R14: clock reset released after supply wait
// R15: pad and core resets released last
// R16: readable wake cause register
// R17: software reconfigures clocks after wakeup
// R18: two outputs switch board supplies
// R19: key value and unlock window parameters
// R20: programmable slow-clock wait counters; the counters here count system-clock cycles
`timescale 1ns/1ns
`default_nettype none
module power_mode_sequencer #(
    parameter logic [31:0] UNLOCK_KEY = 32'h0000_5A3C,
    parameter logic [7:0] UNLOCK_CYCLES = 8'h10
) (
    input wire logic SYS_CLK_IN,
    input wire logic RESETN_IN,
    input wire logic [pwr_seq_pkg::ADDR_W-1:0] ADDR_IN,
    input wire logic [pwr_seq_pkg::DATA_W-1:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [pwr_seq_pkg::DATA_W-1:0] RDATA_OUT,
    input wire logic SLOW_SEL_PAD_IN,
    input wire logic EXT_SLOW_CLK_IN,
    input wire logic SLOW_RING_OSC_IN,
    output logic SLOW_CLK_SEL_EXT_OUT,
    output logic SLOW_CLK_OUT,
    input wire logic WAIT_INSTR_IN,
    input wire logic LOCAL_IRQ_IN,
    input wire logic PIC_IRQ_IN,
    input wire logic [pwr_seq_pkg::WAKE_SRC_W-1:0] WAKE_EVENT_IN,
    output logic CORE_CLK_GATE_OUT,
    output logic SUPPLY_CORE_OUT,
    output logic SUPPLY_PAD_OUT,
    output logic CLOCK_RESET_OUT,
    output logic CORE_RESET_OUT,
    output logic PAD_RESET_OUT,
    output logic PAD_FLOAT_OUT,
    output logic FAST_OSC_DEFAULT_OUT
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        pwr_seq_pkg::pm_state_t state;
        logic mux_sel;
        logic sel_ext;
        logic key_ok;
        logic [pwr_seq_pkg::UNLOCK_W-1:0] unlock_cnt;
        logic [pwr_seq_pkg::WAKE_SRC_W-1:0] wake_en;
        logic [pwr_seq_pkg::CAUSE_W-1:0] cause;
        logic [pwr_seq_pkg::WAIT_W-1:0] supply_wait;
        logic [pwr_seq_pkg::WAIT_W-1:0] clock_wait;
        logic [pwr_seq_pkg::WAIT_W-1:0] cnt;
        logic [pwr_seq_pkg::DATA_W-1:0] rdata;
    } seq_t;

    localparam seq_t SEQ_RST = '{
        state: pwr_seq_pkg::ST_RUN,
        mux_sel: pwr_seq_pkg::MUX_SEL_RST,
        sel_ext: 1'h0,
        key_ok: 1'h0,
        unlock_cnt: '0,
        wake_en: pwr_seq_pkg::WAKE_EN_RST,
        cause: pwr_seq_pkg::CAUSE_RST,
        supply_wait: pwr_seq_pkg::SUPPLY_WAIT_RST,
        clock_wait: pwr_seq_pkg::CLOCK_WAIT_RST,
        cnt: '0,
        rdata: '0
    };

    seq_t seq_reg;
    seq_t seq_next;
    logic irq_any;
    logic wake_hit;

    assign irq_any = LOCAL_IRQ_IN | PIC_IRQ_IN;
    assign wake_hit = |(WAKE_EVENT_IN & seq_reg.wake_en);

    // ****************************************
    // next-state logic
    // ****************************************
    // sequencer, unlock window, register writes and reads
    always_comb begin
        seq_next = seq_reg;
        seq_next.rdata = '0;
        // pad low or software bit picks the external slow clock
        seq_next.sel_ext = ~SLOW_SEL_PAD_IN | seq_reg.mux_sel; // R1 R4
        // unlock expires after its window
        if (seq_reg.key_ok) begin
            if (seq_reg.unlock_cnt == '0) begin
                seq_next.key_ok = 1'b0; // R19
            end else begin
                seq_next.unlock_cnt = seq_reg.unlock_cnt - pwr_seq_pkg::UNLOCK_STEP;
            end
        end
        // power-mode sequencer
        unique case (seq_reg.state)
            pwr_seq_pkg::ST_RUN: begin
                if (WAIT_INSTR_IN && !irq_any) begin
                    seq_next.state = pwr_seq_pkg::ST_WAIT; // R6 R7
                end
            end
            pwr_seq_pkg::ST_WAIT: begin
                if (irq_any) begin
                    seq_next.state = pwr_seq_pkg::ST_RUN; // R8
                end
            end
            pwr_seq_pkg::ST_PDOWN: begin
                // resets and pad float already applied, now drop supplies
                seq_next.state = pwr_seq_pkg::ST_SLEEP; // R11
            end
            pwr_seq_pkg::ST_SLEEP: begin
                if (wake_hit) begin
                    seq_next.state = pwr_seq_pkg::ST_PWRUP; // R12 R13
                    seq_next.cnt = '0;
                    seq_next.cause = '0;
                    seq_next.cause[pwr_seq_pkg::CAUSE_WAKE_BIT] = 1'b1; // R16
                    seq_next.cause[pwr_seq_pkg::CAUSE_SRC_LSB +: pwr_seq_pkg::WAKE_SRC_W] =
                        WAKE_EVENT_IN & seq_reg.wake_en;
                end
            end
            pwr_seq_pkg::ST_PWRUP: begin
                // supplies on, every reset held until supplies settle
                if (seq_reg.cnt >= seq_reg.supply_wait) begin
                    seq_next.state = pwr_seq_pkg::ST_CLKUP; // R14 R20
                    seq_next.cnt = '0;
                end else begin
                    seq_next.cnt = seq_reg.cnt + pwr_seq_pkg::WAIT_STEP;
                end
            end
            pwr_seq_pkg::ST_CLKUP: begin
                // clock reset released, wait for clocks to settle
                if (seq_reg.cnt >= seq_reg.clock_wait) begin
                    seq_next.state = pwr_seq_pkg::ST_RUN; // R15 R20
                    seq_next.cnt = '0;
                end else begin
                    seq_next.cnt = seq_reg.cnt + pwr_seq_pkg::WAIT_STEP;
                end
            end
            default: begin
                seq_next.state = pwr_seq_pkg::ST_RUN;
            end
        endcase
        // register writes; any write other than the key consumes an unlock
        if (WR_IN) begin
            seq_next.key_ok = 1'b0; // R19
            unique case (ADDR_IN)
                pwr_seq_pkg::OFS_SLEEP_KEY: begin
                    if (WDATA_IN == UNLOCK_KEY) begin
                        seq_next.key_ok = 1'b1; // R19
                        seq_next.unlock_cnt = UNLOCK_CYCLES;
                    end
                end
                pwr_seq_pkg::OFS_SLEEP_CMD: begin
                    // refused unless unlocked and running
                    if (seq_reg.key_ok && seq_reg.state == pwr_seq_pkg::ST_RUN) begin
                        seq_next.state = pwr_seq_pkg::ST_PDOWN; // R10 R11
                    end
                end
                pwr_seq_pkg::OFS_WAKE_ENABLE: begin
                    seq_next.wake_en = WDATA_IN[pwr_seq_pkg::WAKE_SRC_W-1:0];
                end
                pwr_seq_pkg::OFS_SUPPLY_WAIT: begin
                    seq_next.supply_wait = WDATA_IN[pwr_seq_pkg::WAIT_W-1:0]; // R20
                end
                pwr_seq_pkg::OFS_CLOCK_WAIT: begin
                    seq_next.clock_wait = WDATA_IN[pwr_seq_pkg::WAIT_W-1:0]; // R20
                end
                pwr_seq_pkg::OFS_SLOW_CLOCK_MUX_CTRL: begin
                    seq_next.mux_sel = WDATA_IN[pwr_seq_pkg::MUX_SEL_BIT]; // R2
                end
                default: begin
                end
            endcase
        end
        // register reads, data stand in the next cycle only
        if (RD_IN) begin
            unique case (ADDR_IN)
                pwr_seq_pkg::OFS_SLOW_CLOCK_MUX_CTRL: begin
                    seq_next.rdata[pwr_seq_pkg::MUX_SEL_BIT] = seq_reg.mux_sel; // R2
                    seq_next.rdata[pwr_seq_pkg::MUX_STATUS_BIT] = SLOW_SEL_PAD_IN; // R3
                end
                pwr_seq_pkg::OFS_WAKE_CAUSE: begin
                    seq_next.rdata[pwr_seq_pkg::CAUSE_W-1:0] = seq_reg.cause; // R16
                end
                pwr_seq_pkg::OFS_WAKE_ENABLE: begin
                    seq_next.rdata[pwr_seq_pkg::WAKE_SRC_W-1:0] = seq_reg.wake_en;
                end
                pwr_seq_pkg::OFS_SUPPLY_WAIT: begin
                    seq_next.rdata[pwr_seq_pkg::WAIT_W-1:0] = seq_reg.supply_wait;
                end
                pwr_seq_pkg::OFS_CLOCK_WAIT: begin
                    seq_next.rdata[pwr_seq_pkg::WAIT_W-1:0] = seq_reg.clock_wait;
                end
                pwr_seq_pkg::OFS_MODE_STATUS: begin
                    seq_next.rdata[pwr_seq_pkg::STATUS_GATED_BIT] =
                        (seq_reg.state == pwr_seq_pkg::ST_WAIT);
                    seq_next.rdata[pwr_seq_pkg::STATUS_UNLOCKED_BIT] = seq_reg.key_ok;
                    seq_next.rdata[pwr_seq_pkg::STATUS_ASLEEP_BIT] =
                        (seq_reg.state == pwr_seq_pkg::ST_SLEEP);
                end
                default: begin
                end
            endcase
        end
    end

    // state register, synchronous active-low reset
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RESETN_IN) begin
            seq_reg <= SEQ_RST;
        end else begin
            seq_reg <= seq_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // clock mux is a plain gate mux; a switch may give one short pulse
    assign SLOW_CLK_SEL_EXT_OUT = seq_reg.sel_ext;
    assign SLOW_CLK_OUT = seq_reg.sel_ext ? EXT_SLOW_CLK_IN : SLOW_RING_OSC_IN; // R1
    assign RDATA_OUT = seq_reg.rdata;
    assign CORE_CLK_GATE_OUT = (seq_reg.state == pwr_seq_pkg::ST_WAIT); // R7
    // supplies are off only while asleep
    assign SUPPLY_CORE_OUT = (seq_reg.state != pwr_seq_pkg::ST_SLEEP); // R18
    assign SUPPLY_PAD_OUT = (seq_reg.state != pwr_seq_pkg::ST_SLEEP); // R18
    // clock reset until supplies settle, core and pad reset until clocks settle
    assign CLOCK_RESET_OUT = (seq_reg.state == pwr_seq_pkg::ST_PDOWN) ||
        (seq_reg.state == pwr_seq_pkg::ST_SLEEP) ||
        (seq_reg.state == pwr_seq_pkg::ST_PWRUP); // R13 R14
    assign CORE_RESET_OUT = CLOCK_RESET_OUT || (seq_reg.state == pwr_seq_pkg::ST_CLKUP); // R15
    assign PAD_RESET_OUT = CORE_RESET_OUT; // R15
    assign PAD_FLOAT_OUT = (seq_reg.state == pwr_seq_pkg::ST_PDOWN) ||
        (seq_reg.state == pwr_seq_pkg::ST_SLEEP); // R11
    // fast clock block loads its ring-oscillator default while clocks reset
    assign FAST_OSC_DEFAULT_OUT = CLOCK_RESET_OUT; // R5

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RESETN_IN);

    a_pad_selects_ext: assert property (!SLOW_SEL_PAD_IN |=> SLOW_CLK_SEL_EXT_OUT) // R1 R4
        else $error("pad low did not select external slow clock");
    a_sw_select_bit: assert property (WR_IN && ADDR_IN == pwr_seq_pkg::OFS_SLOW_CLOCK_MUX_CTRL
        && WDATA_IN[pwr_seq_pkg::MUX_SEL_BIT] |=> ##1 SLOW_CLK_SEL_EXT_OUT) // R2
        else $error("software selector did not pick external clock");
    a_pad_status_read: assert property (RD_IN && ADDR_IN == pwr_seq_pkg::OFS_SLOW_CLOCK_MUX_CTRL
        |=> RDATA_OUT[pwr_seq_pkg::MUX_STATUS_BIT] == $past(SLOW_SEL_PAD_IN)) // R3
        else $error("mux status bit does not show pad level");
    a_wait_gates_clock: assert property (!CORE_CLK_GATE_OUT && !CLOCK_RESET_OUT &&
        !CORE_RESET_OUT && WAIT_INSTR_IN && !irq_any && !WR_IN |=> CORE_CLK_GATE_OUT) // R7
        else $error("wait instruction did not gate clock");
    a_irq_ends_wait: assert property (CORE_CLK_GATE_OUT && irq_any |=> !CORE_CLK_GATE_OUT) // R8
        else $error("interrupt did not end wait mode");
    a_locked_sleep_refused: assert property (WR_IN && ADDR_IN == pwr_seq_pkg::OFS_SLEEP_CMD &&
        !seq_reg.key_ok && seq_reg.state == pwr_seq_pkg::ST_RUN
        |=> !PAD_FLOAT_OUT ##1 SUPPLY_CORE_OUT) // R10
        else $error("sleep command taken without unlock");
    a_sleep_powers_down: assert property (WR_IN && ADDR_IN == pwr_seq_pkg::OFS_SLEEP_CMD &&
        seq_reg.key_ok && seq_reg.state == pwr_seq_pkg::ST_RUN
        |=> PAD_FLOAT_OUT && CORE_RESET_OUT ##1 !SUPPLY_CORE_OUT && !SUPPLY_PAD_OUT) // R11
        else $error("unlocked sleep command did not power down");
    a_wake_supplies_first: assert property (seq_reg.state == pwr_seq_pkg::ST_SLEEP && wake_hit
        |=> SUPPLY_CORE_OUT && SUPPLY_PAD_OUT && CLOCK_RESET_OUT && CORE_RESET_OUT) // R12 R13
        else $error("wakeup did not raise supplies under reset");
    a_clock_reset_order: assert property ($fell(CLOCK_RESET_OUT) |-> SUPPLY_CORE_OUT &&
        CORE_RESET_OUT && $past(seq_reg.cnt) >= $past(seq_reg.supply_wait)) // R14
        else $error("clock reset released before supply wait");
    a_core_release_last: assert property ($fell(CORE_RESET_OUT) |-> !$past(CLOCK_RESET_OUT) &&
        $past(seq_reg.cnt) >= $past(seq_reg.clock_wait)) // R15
        else $error("core reset released before clock wait");
    a_wake_cause_kept: assert property (seq_reg.state == pwr_seq_pkg::ST_SLEEP && wake_hit
        |=> seq_reg.cause[pwr_seq_pkg::CAUSE_WAKE_BIT]) // R16
        else $error("wake cause not recorded");

    c_wait_cycle: cover property (CORE_CLK_GATE_OUT ##1 !CORE_CLK_GATE_OUT);
    c_refused_sleep: cover property (WR_IN && ADDR_IN == pwr_seq_pkg::OFS_SLEEP_CMD &&
        !seq_reg.key_ok);
    c_full_wakeup: cover property (!SUPPLY_CORE_OUT ##1 SUPPLY_CORE_OUT ##[1:64] $fell(CORE_RESET_OUT));

endmodule
`default_nettype wire

// File: tb/core_board_model.sv
// board oscillators and processor power view beside the power-mode sequencer
`timescale 1ns/1ns
`default_nettype none
module core_board_model (
    input wire logic supply_core_in,
    input wire logic supply_pad_in,
    input wire logic core_reset_in,
    input wire logic clk_gate_in,
    output logic ring_osc_out,
    output logic ext_clk_out,
    output logic core_alive_out
);
    // ****************************************
    // slow clock sources
    // ****************************************
    // ring oscillator, free running and unrelated in phase to the system clock
    initial begin
        ring_osc_out = 1'b0;
        forever #170 ring_osc_out = ~ring_osc_out;
    end
    // board oscillator on the external pad, also free running
    initial begin
        ext_clk_out = 1'b1;
        #37;
        forever #230 ext_clk_out = ~ext_clk_out;
    end
    // core runs only with both supplies on, reset released and clock ungated
    assign core_alive_out = supply_core_in & supply_pad_in & ~core_reset_in & ~clk_gate_in;
endmodule
`default_nettype wire

// File: tb/test_power_mode_sequencer.sv
// self-checking testbench for the power-mode sequencer
`timescale 1ns/1ns
`default_nettype none
module test_power_mode_sequencer;
    logic clk, rstn, wr, rd, pad, wait_instr, loc_irq, pic_irq, sel_ext, slow_clk, gate;
    logic ring, ext, alive, fast_def;
    logic [7:0] addr;
    logic [31:0] wdata, rdata;
    logic [3:0] wev;
    logic [5:0] pw;
    int error_cnt, n_tests, n;
    localparam logic [31:0] KEY = 32'h0000_5A3C;

    // ****************************************
    // design and far side
    // ****************************************
    power_mode_sequencer #(.UNLOCK_KEY(KEY), .UNLOCK_CYCLES(8'h10)) DUT (
        .SYS_CLK_IN(clk), .RESETN_IN(rstn), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .SLOW_SEL_PAD_IN(pad),
        .EXT_SLOW_CLK_IN(ext), .SLOW_RING_OSC_IN(ring), .SLOW_CLK_SEL_EXT_OUT(sel_ext),
        .SLOW_CLK_OUT(slow_clk), .WAIT_INSTR_IN(wait_instr),
        .LOCAL_IRQ_IN(loc_irq), .PIC_IRQ_IN(pic_irq),
        .WAKE_EVENT_IN(wev), .CORE_CLK_GATE_OUT(gate), .SUPPLY_CORE_OUT(pw[5]),
        .SUPPLY_PAD_OUT(pw[4]), .CLOCK_RESET_OUT(pw[3]), .CORE_RESET_OUT(pw[2]),
        .PAD_RESET_OUT(pw[1]), .PAD_FLOAT_OUT(pw[0]), .FAST_OSC_DEFAULT_OUT(fast_def));
    core_board_model board (
        .supply_core_in(pw[5]), .supply_pad_in(pw[4]), .core_reset_in(pw[2]),
        .clk_gate_in(gate), .ring_osc_out(ring), .ext_clk_out(ext), .core_alive_out(alive));

    // ****************************************
    // clock, checking and bus tasks
    // ****************************************
    // 100 ns system clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // verdict in one place
    task automatic close_out;
        if (error_cnt == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // compare seen with expected
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // one-cycle write strobe
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // one-cycle read strobe, data checked in the following cycle only
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    // count edges until one sequencer output drops, bounded
    task automatic wait_drop(input int b);
        n = 0;
        while (pw[b] !== 1'b0 && n < 50) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 50) begin
            error_cnt++;
            close_out();
        end
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        {rstn, wr, rd, wait_instr, loc_irq, pic_irq} = 6'h00;
        pad = 1'b1;
        addr = 8'h00;
        wdata = 32'h0;
        wev = 4'h0;
        error_cnt = 0;
        n_tests = 0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        // reset values, unmapped place, pad-chosen clock
        rd_reg(pwr_seq_pkg::OFS_WAKE_CAUSE, 32'h01);
        rd_reg(pwr_seq_pkg::OFS_SUPPLY_WAIT, 32'h10);
        rd_reg(pwr_seq_pkg::OFS_CLOCK_WAIT, 32'h08);
        rd_reg(pwr_seq_pkg::OFS_SLOW_CLOCK_MUX_CTRL, 32'h8000_0000);
        rd_reg(8'h00, 32'h0);
        chk(32'(sel_ext), 32'h0);
        chk(32'(slow_clk), 32'(ring));
        // every pad level against every selector value
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            pad <= i[0];
            wr_reg(pwr_seq_pkg::OFS_SLOW_CLOCK_MUX_CTRL, {31'h0, i[1]});
            rd_reg(pwr_seq_pkg::OFS_SLOW_CLOCK_MUX_CTRL, {i[0], 30'h0, i[1]});
            chk(32'(sel_ext), {31'h0, ~i[0] | i[1]});
            chk(32'(slow_clk), 32'((!i[0] || i[1]) ? ext : ring));
        end
        // wait entered and left by either interrupt, refused while one is pending
        for (int j = 0; j < 3; j++) begin
            @(posedge clk);
            {pic_irq, loc_irq} <= (j == 2) ? 2'h1 : 2'h0;
            wait_instr <= 1'b1;
            @(posedge clk);
            wait_instr <= 1'b0;
            #1;
            chk(32'(gate), (j == 2) ? 32'h0 : 32'h1);
            if (j < 2) begin
                chk(32'(alive), 32'h0);
                repeat (3) @(posedge clk);
                {pic_irq, loc_irq} <= j[0] ? 2'h2 : 2'h1;
                #1;
                chk(32'(gate), 32'h1);
                @(posedge clk);
                #1;
                chk(32'(gate), 32'h0);
            end
            @(posedge clk);
            {pic_irq, loc_irq} <= 2'h0;
        end
        // software looks at the mode status after leaving wait
        rd_reg(pwr_seq_pkg::OFS_MODE_STATUS, 32'h0);
        // sleep refused without key, with a wrong key, after a consuming write
        wr_reg(pwr_seq_pkg::OFS_SLEEP_CMD, 32'h0);
        wr_reg(pwr_seq_pkg::OFS_SLEEP_KEY, KEY ^ 32'h1);
        wr_reg(pwr_seq_pkg::OFS_SLEEP_CMD, 32'h0);
        wr_reg(pwr_seq_pkg::OFS_SLEEP_KEY, KEY);
        wr_reg(pwr_seq_pkg::OFS_WAKE_ENABLE, 32'h1);
        wr_reg(pwr_seq_pkg::OFS_SLEEP_CMD, 32'h0);
        repeat (2) @(posedge clk);
        #1;
        chk(32'(pw), 32'h30);
        // accepted sleep with short wake counts
        wr_reg(pwr_seq_pkg::OFS_SUPPLY_WAIT, 32'h2);
        wr_reg(pwr_seq_pkg::OFS_CLOCK_WAIT, 32'h1);
        wr_reg(pwr_seq_pkg::OFS_SLEEP_KEY, KEY);
        rd_reg(pwr_seq_pkg::OFS_MODE_STATUS, 32'h2);
        wr_reg(pwr_seq_pkg::OFS_SLEEP_CMD, 32'h0);
        #1;
        chk(32'(pw), 32'h3F);
        @(posedge clk);
        #1;
        chk(32'(pw), 32'h0F);
        rd_reg(pwr_seq_pkg::OFS_MODE_STATUS, 32'h4);
        // disabled source stays asleep, enabled one wakes in order
        @(posedge clk);
        wev <= 4'h4;
        repeat (5) @(posedge clk);
        #1;
        chk(32'(pw), 32'h0F);
        @(posedge clk);
        wev <= 4'h1;
        @(posedge clk);
        wev <= 4'h0;
        #1;
        chk(32'(pw[5:1]), 32'h1F);
        chk(32'(fast_def), 32'h1);
        wait_drop(3);
        chk(32'(n), 32'h3);
        chk(32'(pw[2:1]), 32'h3);
        chk(32'(fast_def), 32'h0);
        wait_drop(2);
        chk(32'(n), 32'h2);
        chk(32'({pw, alive}), 32'h61);
        rd_reg(pwr_seq_pkg::OFS_WAKE_CAUSE, 32'h12);
        // software sets its clock choice again after wakeup
        wr_reg(pwr_seq_pkg::OFS_SLOW_CLOCK_MUX_CTRL, 32'h0);
        rd_reg(pwr_seq_pkg::OFS_SLOW_CLOCK_MUX_CTRL, 32'h8000_0000);
        chk(32'(sel_ext), 32'h0);
        close_out();
    end
endmodule
`default_nettype wire
